// File: cip_map.vh
// register map, field positions and constants of the cpu interrupt prioritizer
`ifndef CIP_MAP_VH
`define CIP_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// register indices (byte address is four times the index)
`define CIP_IDX_VECTOR_CONTROL 6'h00
`define CIP_IDX_LEVEL_EXEC_FLAGS 6'h01
`define CIP_IDX_ROTATION_LAST_VECTOR 6'h02
`define CIP_IDX_PROMOTED_VECTOR 6'h03
`define CIP_IDX_PROTECTED_WRITE_UNLOCK 6'h04

////////////////////////////////////////////////////////////////////////////////
// reset values
`define CIP_RST_VECTOR_CONTROL 8'h00
`define CIP_RST_ROTATION_LAST_VECTOR 8'h00
`define CIP_RST_PROMOTED_VECTOR 8'h00

////////////////////////////////////////////////////////////////////////////////
// vector_control fields
`define CIP_BIT_VECTOR_LOCATION_SELECT 6
`define CIP_BIT_COMPACT_TABLE_ENABLE 5
`define CIP_BIT_ROTATION_ENABLE 0

// level_exec_flags fields
`define CIP_BIT_NONMASKABLE_RUNNING 7
`define CIP_BIT_HIGH_LEVEL_RUNNING 1
`define CIP_BIT_NORMAL_LEVEL_RUNNING 0

////////////////////////////////////////////////////////////////////////////////
// protected write unlock (key value arbitrary)
`define CIP_UNLOCK_KEY 8'hA5
`define CIP_UNLOCK_WINDOW 3'h4

////////////////////////////////////////////////////////////////////////////////
// vector numbering
`define CIP_NUM_IRQ 16
`define CIP_NMI_VEC 8'h01
`define CIP_IRQ_BASE_VEC 8'h02
`define CIP_IRQ_END_VEC 8'h12
`define CIP_NO_PROMOTION 8'h00

// compact table slots
`define CIP_SLOT_NMI 8'h01
`define CIP_SLOT_HIGH 8'h02
`define CIP_SLOT_NORMAL 8'h03

// dispatched levels
`define CIP_LVL_NORMAL 2'h0
`define CIP_LVL_HIGH 2'h1
`define CIP_LVL_NMI 2'h2

// application region granule: fuse value shifted left by this is the byte start
`define CIP_FUSE_SHIFT 8
`define CIP_BOOT_START 16'h0000

`endif

// File: cip_arbiter.v
// normal-level arbiter: fixed lowest-vector-first or rotating priority
`include "cip_map.vh"

module cip_arbiter (
    input wire [15:0] req,
    input wire rr_en,
    input wire [7:0] last_vec,
    output wire grant_valid,
    output wire [3:0] grant_idx
);

    // offset of the last acknowledged vector within the request lines
    wire [7:0] last_off;
    // recorded vector names one of our lines
    wire last_in;
    // lines strictly above the last acknowledged one
    wire [15:0] above;
    // requests above the last one
    wire [15:0] upper;
    // candidate set for the lowest-first pick
    wire [15:0] pick;
    // lowest set bit of pick
    wire [15:0] onehot;
    // per index-bit selection of onehot
    wire [63:0] sel;

    assign last_off = last_vec - `CIP_IRQ_BASE_VEC;
    assign last_in = (last_vec >= `CIP_IRQ_BASE_VEC) && (last_vec < `CIP_IRQ_END_VEC);

    // rotation starts just after the recorded vector, else at the lowest
    assign above = (rr_en && last_in) ? ~((16'h0002 << last_off[3:0]) - 16'h0001)
                                      : 16'hFFFF;
    assign upper = req & above;
    // wrap around when nothing is pending above the recorded vector
    assign pick = (|upper) ? upper : req;
    assign onehot = pick & (~pick + 16'h0001);
    assign grant_valid = |req;

    // encode the one-hot grant, one index bit per pass
    genvar b, i;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_enc
            for (i = 0; i < 16; i = i + 1) begin : g_bit
                assign sel[b * 16 + i] = (((i >> b) & 1) != 0) ? onehot[i] : 1'b0;
            end
            assign grant_idx[b] = |sel[b * 16 + 15 : b * 16];
        end
    endgenerate

endmodule // cip_arbiter

// File: cip_top.v
// cpu interrupt prioritizer: apb registers, level tracking and dispatch
//
// Overview of operation
// - vector select: 0 application, 1 boot start
// - boot region first; application start from fuse
// - compact table bit enables compact vector table
// - select/compact need unlock; rotation enable free
// - rotation off: lowest vector wins
// - rotation on: rotating normal-level priority
// - rotation on: record acknowledged normal vector; lowest next
// - after reset lowest vector highest priority
// - nonmaskable flag set while handler runs
// - high flag held through nonmaskable preemption
// - normal flag held through any preemption
// - one promoted vector; zero disables high level
// - unlock key, then protected write within four
// - compact table: slots one, two, three
// - high preempts normal; nothing preempts nonmaskable
`include "cip_map.vh"

module cip_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] boot_region_end_fuse,
    input wire nmi_req,
    input wire [15:0] irq_req,
    input wire cpu_ack,
    input wire return_from_handler,
    output wire irq_valid,
    output wire [1:0] irq_level,
    output wire [7:0] irq_source_vector,
    output wire [7:0] irq_table_slot,
    output wire [15:0] vector_base_addr,
    output wire nonmaskable_running,
    output wire high_level_running,
    output wire normal_level_running
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    // control bits
    reg vsel_reg;
    reg cvt_reg;
    reg rr_reg;
    // rotation and promotion registers
    reg [7:0] last_vec_reg;
    reg [7:0] last_vec_next;
    reg [7:0] promoted_reg;
    // running flags
    reg nmi_run_reg;
    reg hi_run_reg;
    reg lo_run_reg;
    // unlock window, counts remaining accesses
    reg [2:0] unlock_reg;
    reg [2:0] unlock_next;
    // fuse synchroniser
    reg [7:0] fuse_meta_reg;
    reg [7:0] fuse_reg;
    // read data and offer registers
    reg [31:0] prdata_reg;
    reg [31:0] rdata_next;
    reg valid_reg;
    reg [1:0] level_reg;
    reg [7:0] src_reg;
    reg [7:0] slot_reg;
    reg valid_next;
    reg [1:0] level_next;
    reg [7:0] src_next;
    reg [7:0] slot_next;
    reg [15:0] base_reg;

    // bus decode
    wire [5:0] word;
    wire setup;
    wire access;
    wire wr;
    wire mapped;
    wire ctrl_wr;
    wire unlock_open;
    // request classification
    wire [15:0] hi_mask;
    wire [15:0] lo_req;
    wire [15:0] hi_hits;
    wire hi_pend;
    wire [3:0] hi_idx;
    wire lo_valid;
    wire [3:0] lo_idx;
    wire [7:0] lo_vec;
    wire [7:0] level_flags;
    // acknowledges of the standing offer
    wire take;
    wire take_nmi;
    wire take_hi;
    wire take_lo;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, error on unmapped words

    assign word = paddr[7:2];
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign mapped = (word <= `CIP_IDX_PROTECTED_WRITE_UNLOCK) && (paddr[1:0] == 2'h0);
    assign ctrl_wr = wr && mapped && (word == `CIP_IDX_VECTOR_CONTROL);
    assign unlock_open = (unlock_reg != 3'h0);
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign prdata = prdata_reg;

    assign level_flags = {nmi_run_reg, 5'h00, hi_run_reg, lo_run_reg};

    // read mux, sampled in the setup cycle
    always @* begin
        rdata_next = 32'h0000_0000;
        if (!mapped) begin
            rdata_next = 32'h0000_0000;
        end else if (word == `CIP_IDX_VECTOR_CONTROL) begin
            rdata_next[`CIP_BIT_VECTOR_LOCATION_SELECT] = vsel_reg;
            rdata_next[`CIP_BIT_COMPACT_TABLE_ENABLE] = cvt_reg;
            rdata_next[`CIP_BIT_ROTATION_ENABLE] = rr_reg;
        end else if (word == `CIP_IDX_LEVEL_EXEC_FLAGS) begin
            rdata_next[7:0] = level_flags;
        end else if (word == `CIP_IDX_ROTATION_LAST_VECTOR) begin
            rdata_next[7:0] = last_vec_reg;
        end else if (word == `CIP_IDX_PROMOTED_VECTOR) begin
            rdata_next[7:0] = promoted_reg;
        end else begin
            // unlock register reads open window count
            rdata_next[2:0] = unlock_reg;
        end
    end

    // read data register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup) begin
            prdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // protected write unlock window

    always @* begin
        unlock_next = unlock_reg;
        if (wr && mapped && (word == `CIP_IDX_PROTECTED_WRITE_UNLOCK)) begin
            // key opens the window, anything else closes it
            unlock_next = (pwdata[7:0] == `CIP_UNLOCK_KEY) ? `CIP_UNLOCK_WINDOW : 3'h0;
        end else if (ctrl_wr) begin
            // protected write consumes the window
            unlock_next = 3'h0;
        end else if (access && unlock_open) begin
            // each other access uses one slot
            unlock_next = unlock_reg - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and vector registers

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vsel_reg <= `CIP_RST_VECTOR_CONTROL == 8'h00 ? 1'b0 : 1'b1;
            cvt_reg <= 1'b0;
            rr_reg <= 1'b0;
            promoted_reg <= `CIP_RST_PROMOTED_VECTOR;
            unlock_reg <= 3'h0;
        end else begin
            unlock_reg <= unlock_next;
            if (ctrl_wr) begin
                // rotation enable needs no unlock
                rr_reg <= pwdata[`CIP_BIT_ROTATION_ENABLE];
                if (unlock_open) begin
                    // guarded bits change only inside the window
                    vsel_reg <= pwdata[`CIP_BIT_VECTOR_LOCATION_SELECT];
                    cvt_reg <= pwdata[`CIP_BIT_COMPACT_TABLE_ENABLE];
                end
            end
            if (wr && mapped && (word == `CIP_IDX_PROMOTED_VECTOR)) begin
                promoted_reg <= pwdata[7:0];
            end
        end
    end

    // last vector: hardware record wins over a software write
    always @* begin
        last_vec_next = last_vec_reg;
        if (wr && mapped && (word == `CIP_IDX_ROTATION_LAST_VECTOR)) begin
            last_vec_next = pwdata[7:0];
        end
        if (take_lo && rr_reg) begin
            last_vec_next = src_reg;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_vec_reg <= `CIP_RST_ROTATION_LAST_VECTOR;
        end else begin
            last_vec_reg <= last_vec_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // vector placement from the boot end fuse

    // two-flop synchroniser for the fuse strap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fuse_meta_reg <= 8'h00;
            fuse_reg <= 8'h00;
            base_reg <= `CIP_BOOT_START;
        end else begin
            fuse_meta_reg <= boot_region_end_fuse;
            fuse_reg <= fuse_meta_reg;
            // boot region sits first, application follows at the fuse
            base_reg <= vsel_reg ? `CIP_BOOT_START
                                 : {fuse_reg, {`CIP_FUSE_SHIFT{1'b0}}};
        end
    end
    assign vector_base_addr = base_reg;

    ////////////////////////////////////////////////////////////////////////////
    // request classification

    // one line at most matches the promoted vector; zero matches none
    genvar gi;
    generate
        for (gi = 0; gi < `CIP_NUM_IRQ; gi = gi + 1) begin : g_hi
            assign hi_mask[gi] = (promoted_reg != `CIP_NO_PROMOTION) &&
                                 (promoted_reg == `CIP_IRQ_BASE_VEC + gi);
        end
    endgenerate

    assign hi_hits = irq_req & hi_mask;
    assign hi_pend = |hi_hits;
    assign lo_req = irq_req & ~hi_mask;

    // high level has a single source, so a fixed encode suffices
    cip_arbiter u_hi_enc (
        .req(hi_hits),
        .rr_en(1'b0),
        .last_vec(8'h00),
        .grant_valid(),
        .grant_idx(hi_idx)
    );

    // normal-level arbitration
    cip_arbiter u_lo_arb (
        .req(lo_req),
        .rr_en(rr_reg),
        .last_vec(last_vec_reg),
        .grant_valid(lo_valid),
        .grant_idx(lo_idx)
    );

    assign lo_vec = {4'h0, lo_idx} + `CIP_IRQ_BASE_VEC;

    ////////////////////////////////////////////////////////////////////////////
    // offer selection and preemption

    assign take = cpu_ack & valid_reg;
    assign take_nmi = take && (level_reg == `CIP_LVL_NMI);
    assign take_hi = take && (level_reg == `CIP_LVL_HIGH);
    assign take_lo = take && (level_reg == `CIP_LVL_NORMAL);

    always @* begin
        valid_next = 1'b0;
        level_next = `CIP_LVL_NORMAL;
        src_next = 8'h00;
        slot_next = 8'h00;
        if (take || nmi_run_reg) begin
            // idle a cycle after a take; nothing preempts a nonmaskable handler
            valid_next = 1'b0;
        end else if (nmi_req) begin
            valid_next = 1'b1;
            level_next = `CIP_LVL_NMI;
            src_next = `CIP_NMI_VEC;
            slot_next = cvt_reg ? `CIP_SLOT_NMI : `CIP_NMI_VEC;
        end else if (hi_run_reg) begin
            valid_next = 1'b0;
        end else if (hi_pend) begin
            // high level may preempt a running normal handler
            valid_next = 1'b1;
            level_next = `CIP_LVL_HIGH;
            src_next = {4'h0, hi_idx} + `CIP_IRQ_BASE_VEC;
            slot_next = cvt_reg ? `CIP_SLOT_HIGH : src_next;
        end else if (lo_run_reg) begin
            valid_next = 1'b0;
        end else if (lo_valid) begin
            valid_next = 1'b1;
            level_next = `CIP_LVL_NORMAL;
            src_next = lo_vec;
            slot_next = cvt_reg ? `CIP_SLOT_NORMAL : lo_vec;
        end
    end

    // offer registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valid_reg <= 1'b0;
            level_reg <= `CIP_LVL_NORMAL;
            src_reg <= 8'h00;
            slot_reg <= 8'h00;
        end else begin
            valid_reg <= valid_next;
            level_reg <= level_next;
            src_reg <= src_next;
            slot_reg <= slot_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // running flags: set on take, return clears the innermost level

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_run_reg <= 1'b0;
            hi_run_reg <= 1'b0;
            lo_run_reg <= 1'b0;
        end else begin
            if (take_nmi) begin
                nmi_run_reg <= 1'b1;
            end else if (return_from_handler && nmi_run_reg) begin
                nmi_run_reg <= 1'b0;
            end
            if (take_hi) begin
                hi_run_reg <= 1'b1;
            end else if (return_from_handler && !nmi_run_reg && hi_run_reg) begin
                hi_run_reg <= 1'b0;
            end
            if (take_lo) begin
                lo_run_reg <= 1'b1;
            end else if (return_from_handler && !nmi_run_reg && !hi_run_reg) begin
                lo_run_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign irq_valid = valid_reg;
    assign irq_level = level_reg;
    assign irq_source_vector = src_reg;
    assign irq_table_slot = slot_reg;
    assign nonmaskable_running = nmi_run_reg;
    assign high_level_running = hi_run_reg;
    assign normal_level_running = lo_run_reg;

endmodule // cip_top

// File: cip_core_model.sv
// cpu core model: takes standing offers after a chosen delay
module cip_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_valid,
    input wire logic [1:0] lat,
    output logic cpu_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_cnt; // cycles the offer has stood
    // one-cycle take pulse once the offer has waited lat cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (irq_valid && !cpu_ack && wait_cnt >= lat) begin
            cpu_ack <= 1'b1;
            wait_cnt <= 2'h0;
        end else begin
            cpu_ack <= 1'b0;
            wait_cnt <= irq_valid ? wait_cnt + 2'h1 : 2'h0;
        end
    end
endmodule // cip_core_model

// File: cip_top_props.sv
// assertion checker on the ports of the interrupt prioritizer
`include "cip_map.vh"
module cip_top_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic nmi_req,
    input wire logic [15:0] irq_req,
    input wire logic cpu_ack,
    input wire logic return_from_handler,
    input wire logic irq_valid,
    input wire logic [1:0] irq_level,
    input wire logic [7:0] irq_source_vector,
    input wire logic [7:0] irq_table_slot,
    input wire logic nonmaskable_running,
    input wire logic high_level_running,
    input wire logic normal_level_running
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dck @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire take = irq_valid && cpu_ack; // core takes the offer
    ////////////////////////////////////////
    AST_SLVERR: assert property (
        psel && penable && (paddr[7:2] > 6'h04 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access gave no error");
    AST_NMI_SET: assert property (
        take && irq_level == `CIP_LVL_NMI |=> nonmaskable_running)
        else $error("nonmaskable flag not set");
    AST_NMI_CLEAR: assert property (
        nonmaskable_running && return_from_handler |=> !nonmaskable_running)
        else $error("nonmaskable flag not cleared");
    AST_HIGH_SET: assert property (
        take && irq_level == `CIP_LVL_HIGH |=> high_level_running)
        else $error("high flag not set");
    AST_HIGH_HELD: assert property (
        high_level_running && (nonmaskable_running || !return_from_handler)
        |=> high_level_running) else $error("high flag lost early");
    AST_NORMAL_SET: assert property (
        take && irq_level == `CIP_LVL_NORMAL |=> normal_level_running)
        else $error("normal flag not set");
    AST_NORMAL_HELD: assert property (
        normal_level_running && (high_level_running || nonmaskable_running
        || !return_from_handler) |=> normal_level_running) else $error("normal flag lost");
    AST_NMI_BLOCK: assert property (
        nonmaskable_running |-> !irq_valid) else $error("offer during nonmaskable handler");
    AST_SLOT: assert property (
        irq_valid |-> irq_table_slot == irq_source_vector
        || irq_table_slot == (irq_level == `CIP_LVL_NMI ? `CIP_SLOT_NMI
        : irq_level == `CIP_LVL_HIGH ? `CIP_SLOT_HIGH : `CIP_SLOT_NORMAL))
        else $error("bad table slot");
    AST_NORMAL_SRC: assert property (
        irq_valid && irq_level == `CIP_LVL_NORMAL
        |-> (($past(irq_req) >> (irq_source_vector - 8'h02)) & 16'h0001) == 16'h0001)
        else $error("normal offer without request");
    AST_NMI_SRC: assert property (
        irq_valid && irq_level == `CIP_LVL_NMI |-> irq_source_vector == `CIP_NMI_VEC
        && $past(nmi_req)) else $error("bad nonmaskable offer");
    cover property (nonmaskable_running && high_level_running && normal_level_running);
    cover property (take && irq_level == `CIP_LVL_HIGH);
    cover property (psel && penable && pslverr);
endmodule // cip_top_props
bind cip_top cip_top_props cip_top_props_i (.pclk, .presetn, .psel, .penable, .paddr,
    .pslverr, .nmi_req, .irq_req, .cpu_ack, .return_from_handler, .irq_valid, .irq_level,
    .irq_source_vector, .irq_table_slot, .nonmaskable_running, .high_level_running,
    .normal_level_running);

// File: cip_top_tb.sv
// self-checking testbench of the interrupt prioritizer
`include "cip_map.vh"
module cip_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic nmi_req = 1'b0, ret = 1'b0, pready, pslverr, valid, ack, nmi_run, hi_run, lo_run;
    logic [7:0] paddr = 8'h00, fuse = 8'h3C, src, slot, last = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0001447A;
    logic [15:0] irq_req = 16'h0000, vbase;
    logic [1:0] lvl, lat = 2'h0;
    logic [32:0] exp_rd[$]; // expected {error, read data}
    logic [17:0] exp_ack[$]; // expected {level, source, slot}
    int n_mismatch = 0, samples_checked = 0;
    cip_top cip_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_region_end_fuse(fuse), .nmi_req(nmi_req), .irq_req(irq_req),
        .cpu_ack(ack), .return_from_handler(ret), .irq_valid(valid), .irq_level(lvl),
        .irq_source_vector(src), .irq_table_slot(slot), .vector_base_addr(vbase),
        .nonmaskable_running(nmi_run), .high_level_running(hi_run),
        .normal_level_running(lo_run));
    cip_core_model cip_core_model_i (.pclk(pclk), .presetn(presetn), .irq_valid(valid),
        .lat(lat), .cpu_ack(ack));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // xorshift source of stimulus
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected winner: lowest line, or first line after the last served one
    function automatic logic [7:0] pick(input logic [15:0] r, input logic rr,
                                        input logic [7:0] lv);
        int i, s;
        s = (rr && lv >= 8'h02 && lv <= 8'h11) ? int'(lv) - 1 : 0;
        for (i = 0; i < 16; i++)
            if (r[(s + i) % 16]) return 8'((s + i) % 16 + 2);
        return 8'h00;
    endfunction
    // one apb transfer; reads leave their expectation in the queue
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d,
                       input logic [32:0] e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        if (!wr) exp_rd.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // raise requests, wait for the core to take the offer, drop them
    task automatic serve(input logic [15:0] r, input logic n, input logic [17:0] e);
        int k;
        exp_ack.push_back(e);
        irq_req <= r;
        nmi_req <= n;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (!(valid === 1'b1 && ack === 1'b1) && k < 50);
        irq_req <= 16'h0000;
        nmi_req <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ret_pulse;
        ret <= 1'b1;
        @(posedge pclk);
        ret <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic flags(input logic [2:0] e);
        check("running flags", 33'({nmi_run, hi_run, lo_run}), 33'(e));
    endtask
    // watcher: every completed read and every taken offer against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && exp_rd.size() > 0)
            check("read", {pslverr, prdata}, exp_rd.pop_front());
        if (valid && ack && exp_ack.size() > 0)
            check("offer", 33'({lvl, src, slot}), 33'(exp_ack.pop_front()));
    end
    initial forever #10 pclk = ~pclk;
    initial begin
        repeat (4000) @(posedge pclk);
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        int i;
        logic [15:0] r;
        logic [7:0] v;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 4; i++) apb(1'b0, 6'(i), 32'h0, 33'h0);
        apb(1'b0, 6'h05, 32'h0, 33'h100000000);
        check("base", 33'(vbase), {17'h00000, fuse, 8'h00});
        for (i = 0; i < 16; i++) begin
            if (i == 8) apb(1'b1, 6'h00, 32'h1, 33'h0);
            r = 16'(rnd()) | 16'h0100;
            lat <= 2'(rnd());
            v = pick(r, i >= 8, last);
            serve(r, 1'b0, {`CIP_LVL_NORMAL, v, v});
            if (i >= 8) last = v;
            flags(3'b001);
            ret_pulse;
        end
        apb(1'b0, 6'h02, 32'h0, 33'(last));
        apb(1'b1, 6'h02, 32'h4, 33'h0);
        serve(16'h0104, 1'b0, {`CIP_LVL_NORMAL, 8'h0A, 8'h0A});
        ret_pulse;
        apb(1'b1, 6'h00, 32'h60, 33'h0);
        apb(1'b0, 6'h00, 32'h0, 33'h0);
        apb(1'b1, 6'h04, 32'hA5, 33'h0);
        repeat (4) apb(1'b0, 6'h00, 32'h0, 33'h0);
        apb(1'b1, 6'h00, 32'h60, 33'h0);
        apb(1'b0, 6'h00, 32'h0, 33'h0);
        apb(1'b1, 6'h04, 32'hA5, 33'h0);
        repeat (3) apb(1'b0, 6'h00, 32'h0, 33'h0);
        apb(1'b1, 6'h00, 32'hFE, 33'h0);
        apb(1'b0, 6'h00, 32'h0, 33'h60);
        check("base", 33'(vbase), 33'h0);
        apb(1'b1, 6'h03, 32'h5, 33'h0);
        apb(1'b0, 6'h03, 32'h0, 33'h5);
        serve(16'h0001, 1'b0, {`CIP_LVL_NORMAL, 8'h02, `CIP_SLOT_NORMAL});
        serve(16'h0008, 1'b0, {`CIP_LVL_HIGH, 8'h05, `CIP_SLOT_HIGH});
        flags(3'b011);
        serve(16'h0000, 1'b1, {`CIP_LVL_NMI, `CIP_NMI_VEC, `CIP_SLOT_NMI});
        flags(3'b111);
        irq_req <= 16'h0009;
        repeat (3) @(posedge pclk);
        check("offer under nmi", 33'(valid), 33'h0);
        irq_req <= 16'h0000;
        @(posedge pclk);
        ret_pulse;
        flags(3'b011);
        ret_pulse;
        flags(3'b001);
        ret_pulse;
        flags(3'b000);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, 6'h00, 32'h1, 33'h0);
        serve(16'hFFFF, 1'b0, {`CIP_LVL_NORMAL, 8'h02, 8'h02});
        ret_pulse;
        check("base after reset", 33'(vbase), {17'h00000, fuse, 8'h00});
        check("notes left", 33'(exp_ack.size() + exp_rd.size()), 33'h0);
        report_and_stop;
    end
endmodule // cip_top_tb
